// file: hdl/cmsf_core_regs.sv
/*
 Core memory map and special-function registers: program flash decode and
 protection, internal RAM with banks and stack, expanded RAM and external bus,
 accumulators, status word, dual data pointers and system control flags.
 Assumes the execution core presents at most one request per port per cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmsf_consts.svh"
module cmsf_core_regs
	import cmsf_pkg::*;
#(
	parameter int unsigned ERASE_CYCLES = `CMSF_ERASE_CYC
) (
	input  wire logic            sys_clk,           // System clock
	input  wire logic            reset_n,           // Synchronous reset
	input  wire logic            clk_en,            // Freezes state when low
	input  wire cmsf_sfr_req_t   sfr_req,           // Register write from core
	output logic          [7:0]  sfr_rdata,         // Register read data
	input  wire logic      [7:0] iram_addr,         // Internal RAM address
	input  wire logic            iram_indirect,     // Access is indirect
	input  wire logic            iram_rn_sel,       // Working register access
	input  wire logic      [2:0] iram_rn_idx,       // Working register index
	input  wire logic            iram_wr,           // Internal RAM write
	input  wire logic      [7:0] iram_wdata,        // Internal RAM write data
	output logic          [7:0]  iram_rdata,        // Internal RAM read data
	output logic                 direct_is_sfr,     // Direct address hits registers
	output logic                 in_bit_area,       // Address in bit area
	input  wire logic            push_req,          // Stack push
	input  wire logic      [7:0] push_data,         // Byte to push
	input  wire logic            pop_req,           // Stack pop
	output logic          [7:0]  pop_data,          // Popped byte
	input  wire logic            acc_load,          // Core result into accumulator
	input  wire logic      [7:0] acc_in,            // Accumulator value
	input  wire logic            b_load,            // Multiply/divide result
	input  wire logic      [7:0] b_in,              // Second accumulator value
	input  wire logic            flags_load,        // Arithmetic flags update
	input  wire logic      [2:0] flags_in,          // Carry, half carry, overflow
	output logic          [7:0]  accumulator,       // Accumulator contents
	output logic          [7:0]  second_accumulator,// Second accumulator contents
	output logic          [7:0]  program_status,    // Status word with parity
	output logic          [7:0]  stack_pointer,     // Stack pointer
	output logic          [7:0]  bank_base,         // Working register base
	input  wire logic            data_pointer0_load16,       // Load active pointer word
	input  wire logic     [15:0] data_pointer0_in,           // Pointer word
	output logic         [15:0]  active_pointer,    // Selected data pointer
	input  wire logic     [15:0] fetch_addr,        // Code address
	input  wire logic            table_rd,          // Code table read
	input  wire logic            external_program_select, // Pin, low selects external
	output logic                 fetch_external,    // Code address beyond flash
	output logic                 table_read_blocked,// Table read disabled
	output logic          [7:0]  code_rdata,        // Code byte
	output logic                 fetch_in_service,  // Address in service area
	output logic         [14:0]  service_base,      // Start of service area
	input  wire logic      [3:0] info_service_blocks, // Information block value
	input  wire cmsf_xdata_req_t xd_req,            // External data move
	input  wire logic      [7:0] ext_rdata,         // External bus read data
	output cmsf_ext_bus_t        ext_bus,           // External bus controls
	output logic          [7:0]  xd_rdata,          // Move read data
	output logic                 xd_valid,          // Move read data valid
	input  wire logic            latch_tick,        // Core latch strobe timing
	output logic                 latch_strobe,      // Address latch enable out
	output logic                 insys_prog_enable, // Programming enabled
	input  wire logic            iap_write,         // Core flash byte write
	input  wire logic            prog_erase,        // Programmer erase
	input  wire logic            prog_write,        // Programmer byte write
	input  wire logic            prog_protect_set,  // Programmer sets protection
	input  wire logic     [13:0] prog_addr,         // Programmer address
	input  wire logic      [7:0] prog_wdata,        // Programmer write data
	output logic          [7:0]  prog_rdata,        // Programmer read data
	output logic                 code_protected,    // Protection bit
	output logic                 flash_busy,        // Flash operation running
	output logic                 flash_refused      // Pulse: flash write refused
);
	logic [7:0]  iram [0:255];
	logic [7:0]  xram [0:`CMSF_XRAM_BYTES-1];
	logic [7:0]  acc_reg;
	logic [7:0]  b_reg;
	cmsf_psw_t   psw_reg;
	logic [7:0]  sp_reg;
	logic [15:0] ptr0_reg;
	logic [15:0] ptr1_reg;
	logic        psel_reg;
	logic [2:0]  sysctl_reg;
	logic        protect_reg;
	logic [3:0]  svc_blocks_reg;
	logic        cfg_taken_reg;
	logic        blocked_reg;
	logic        ext_pend_reg;
	logic [7:0]  sfr_rd_next;
	logic        erase_done;
	logic [7:0]  flash_rd_a;
	logic [7:0]  flash_rd_b;

	// Register write decode
	wire logic wr_sp     = sfr_req.wr && (sfr_req.addr == `CMSF_ADDR_SP);
	wire logic wr_p0lo   = sfr_req.wr && (sfr_req.addr == `CMSF_ADDR_P0LO);
	wire logic wr_p0hi   = sfr_req.wr && (sfr_req.addr == `CMSF_ADDR_P0HI);
	wire logic wr_p1lo   = sfr_req.wr && (sfr_req.addr == `CMSF_ADDR_P1LO);
	wire logic wr_p1hi   = sfr_req.wr && (sfr_req.addr == `CMSF_ADDR_P1HI);
	wire logic wr_psel   = sfr_req.wr && (sfr_req.addr == `CMSF_ADDR_PSEL);
	wire logic wr_sysctl = sfr_req.wr && (sfr_req.addr == `CMSF_ADDR_SYSCTL);
	wire logic wr_psw    = sfr_req.wr && (sfr_req.addr == `CMSF_ADDR_PSW);
	wire logic wr_acc    = sfr_req.wr && (sfr_req.addr == `CMSF_ADDR_ACC);
	wire logic wr_b      = sfr_req.wr && (sfr_req.addr == `CMSF_ADDR_B);

	// Parity and working register bank
	wire logic parity_now = ^acc_reg; // see RULE16
	assign bank_base      = {3'b000, psw_reg.bank_select, 3'b000}; // see RULE15

	assign accumulator        = acc_reg;
	assign second_accumulator = b_reg; // see RULE20
	assign program_status     = {psw_reg[7:1], parity_now};
	assign stack_pointer      = sp_reg;
	assign active_pointer     = psel_reg ? ptr1_reg : ptr0_reg; // see RULE19
	assign insys_prog_enable  = sysctl_reg[`CMSF_BIT_ISP_EN]; // see RULE21
	assign code_protected     = protect_reg;

	// Internal RAM decode
	assign direct_is_sfr = !iram_rn_sel && !iram_indirect && iram_addr[7]; // see RULE14
	assign in_bit_area   = (iram_addr >= `CMSF_BIT_AREA_LO) && (iram_addr <= `CMSF_BIT_AREA_HI);
	wire logic [7:0] ram_addr = iram_rn_sel ? (bank_base | {5'b00000, iram_rn_idx}) : iram_addr; // see RULE13
	wire logic [7:0] sp_inc   = sp_reg + 8'd1;
	wire logic [7:0] sp_dec   = sp_reg - 8'd1;
	wire logic       ram_we   = push_req || (iram_wr && !direct_is_sfr);
	wire logic [7:0] ram_wa   = push_req ? sp_inc : ram_addr; // see RULE17
	wire logic [7:0] ram_wd   = push_req ? push_data : iram_wdata;

	// Program memory decode and service area
	assign service_base     = 15'(`CMSF_FLASH_END) - {svc_blocks_reg, 9'h000}; // see RULE5
	assign fetch_external   = (fetch_addr > `CMSF_FLASH_TOP); // see RULE1
	assign fetch_in_service = !fetch_external && ({1'b0, fetch_addr[13:0]} >= service_base);
	assign table_read_blocked = table_rd && protect_reg && !external_program_select; // see RULE7
	assign code_rdata       = blocked_reg ? `CMSF_RST_ZERO : flash_rd_a;
	assign prog_rdata       = protect_reg ? `CMSF_RST_ZERO : flash_rd_b; // see RULE8

	// External data move decode
	wire logic [15:0] xd_addr = xd_req.wide ? xd_req.addr : {8'h00, xd_req.addr[7:0]};
	wire logic xd_any   = xd_req.rd || xd_req.wr;
	wire logic xram_hit = sysctl_reg[`CMSF_BIT_XRAM_EN] && (xd_addr <= `CMSF_XRAM_TOP); // see RULE10
	wire logic xd_ext   = xd_any && !xram_hit; // see RULE11
	wire logic [9:0] xidx = xd_addr[9:0];

	assign latch_strobe = (latch_tick && !sysctl_reg[`CMSF_BIT_LSTRB_INH]) || !ext_bus.rd_n
		|| !ext_bus.wr_n; // see RULE21

	// Flash request arbitration; the programmer wins over the core
	wire logic        fl_write = prog_write || (iap_write && sysctl_reg[`CMSF_BIT_ISP_EN]);
	wire logic [13:0] fl_waddr = prog_write ? prog_addr : data_pointer0_in[13:0];
	wire logic [7:0]  fl_wdata = prog_write ? prog_wdata : acc_reg;

	always_comb begin
		case (sfr_req.addr)
			`CMSF_ADDR_SP:     sfr_rd_next = sp_reg;
			`CMSF_ADDR_P0LO:   sfr_rd_next = ptr0_reg[7:0];
			`CMSF_ADDR_P0HI:   sfr_rd_next = ptr0_reg[15:8];
			`CMSF_ADDR_P1LO:   sfr_rd_next = ptr1_reg[7:0];
			`CMSF_ADDR_P1HI:   sfr_rd_next = ptr1_reg[15:8];
			`CMSF_ADDR_PSEL:   sfr_rd_next = {7'h00, psel_reg}; // see RULE22
			`CMSF_ADDR_SYSCTL: sfr_rd_next = {5'h00, sysctl_reg}; // see RULE22
			`CMSF_ADDR_PSW:    sfr_rd_next = program_status;
			`CMSF_ADDR_ACC:    sfr_rd_next = acc_reg;
			`CMSF_ADDR_B:      sfr_rd_next = b_reg;
			default:           sfr_rd_next = `CMSF_RST_ZERO;
		endcase
	end

	cmsf_flash_array #(
		.ERASE_CYCLES (ERASE_CYCLES)
	) u_flash (
		.sys_clk       (sys_clk),
		.reset_n       (reset_n),
		.clk_en        (clk_en),
		.erase_req     (prog_erase),
		.write_req     (fl_write),
		.wr_addr       (fl_waddr),
		.wr_data       (fl_wdata),
		.rd_addr_a     (fetch_addr[13:0]),
		.rd_addr_b     (prog_addr),
		.rd_data_a     (flash_rd_a),
		.rd_data_b     (flash_rd_b),
		.busy          (flash_busy),
		.write_refused (flash_refused),
		.erase_done    (erase_done)
	);

	// Accumulators and status word; core loads win over register writes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			acc_reg <= `CMSF_RST_ZERO;
			b_reg   <= `CMSF_RST_ZERO;
			psw_reg <= '0;
		end else if (clk_en) begin
			if (acc_load)
				acc_reg <= acc_in;
			else if (wr_acc)
				acc_reg <= sfr_req.wdata;
			if (b_load)
				b_reg <= b_in; // see RULE20
			else if (wr_b)
				b_reg <= sfr_req.wdata;
			if (wr_psw)
				psw_reg <= {sfr_req.wdata[7:1], 1'b0};
			if (flags_load) begin
				psw_reg.carry_flag      <= flags_in[2];
				psw_reg.half_carry_flag <= flags_in[1];
				psw_reg.overflow_flag   <= flags_in[0];
			end
		end
	end

	// Stack pointer and data pointers
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sp_reg   <= `CMSF_RST_SP; // see RULE17
			ptr0_reg <= '0;
			ptr1_reg <= '0;
			psel_reg <= 1'b0;
		end else if (clk_en) begin
			if (push_req)
				sp_reg <= sp_inc; // see RULE17
			else if (pop_req)
				sp_reg <= sp_dec;
			else if (wr_sp)
				sp_reg <= sfr_req.wdata;
			if (data_pointer0_load16 && !psel_reg)
				ptr0_reg <= data_pointer0_in; // see RULE18
			else if (wr_p0lo)
				ptr0_reg[7:0] <= sfr_req.wdata;
			else if (wr_p0hi)
				ptr0_reg[15:8] <= sfr_req.wdata;
			if (data_pointer0_load16 && psel_reg)
				ptr1_reg <= data_pointer0_in; // see RULE18
			else if (wr_p1lo)
				ptr1_reg[7:0] <= sfr_req.wdata;
			else if (wr_p1hi)
				ptr1_reg[15:8] <= sfr_req.wdata;
			if (wr_psel)
				psel_reg <= sfr_req.wdata[`CMSF_BIT_PSEL]; // see RULE19
		end
	end

	// Control flags, protection and service configuration
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			sysctl_reg     <= 3'b000; // see RULE12
			protect_reg    <= 1'b0;
			svc_blocks_reg <= 4'h0;
			cfg_taken_reg  <= 1'b0;
			blocked_reg    <= 1'b0;
			sfr_rdata      <= `CMSF_RST_ZERO;
		end else if (clk_en) begin
			if (wr_sysctl)
				sysctl_reg <= sfr_req.wdata[2:0]; // see RULE21
			if (prog_protect_set)
				protect_reg <= 1'b1;
			else if (erase_done)
				protect_reg <= 1'b0; // see RULE9
			if (!cfg_taken_reg) begin
				cfg_taken_reg  <= 1'b1;
				svc_blocks_reg <= (info_service_blocks > `CMSF_SVC_MAX) ? `CMSF_SVC_MAX
					: info_service_blocks; // see RULE6
			end
			blocked_reg <= table_read_blocked;
			sfr_rdata   <= sfr_rd_next;
		end
	end

	// Internal RAM with stack access
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			iram_rdata <= `CMSF_RST_ZERO;
			pop_data   <= `CMSF_RST_ZERO;
		end else if (clk_en) begin
			if (ram_we)
				iram[ram_wa] <= ram_wd;
			iram_rdata <= iram[ram_addr];
			if (pop_req)
				pop_data <= iram[sp_reg];
		end
	end

	// Expanded RAM and external bus
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			ext_bus      <= '{addr: 16'h0000, rd_n: 1'b1, wr_n: 1'b1, wdata: 8'h00};
			ext_pend_reg <= 1'b0;
			xd_rdata     <= `CMSF_RST_ZERO;
			xd_valid     <= 1'b0;
		end else if (clk_en) begin
			ext_bus.rd_n <= !(xd_ext && xd_req.rd); // see RULE11
			ext_bus.wr_n <= !(xd_ext && xd_req.wr);
			if (xd_ext) begin
				ext_bus.addr  <= xd_addr;
				ext_bus.wdata <= xd_req.wdata;
			end
			ext_pend_reg <= xd_ext && xd_req.rd;
			xd_valid     <= ext_pend_reg || (xd_req.rd && xram_hit);
			if (ext_pend_reg)
				xd_rdata <= ext_rdata;
			else if (xd_req.rd && xram_hit)
				xd_rdata <= xram[xidx]; // see RULE10
			if (xd_req.wr && xram_hit)
				xram[xidx] <= xd_req.wdata; // see RULE12
		end
	end
endmodule
`default_nettype wire

// file: pkg/cmsf_consts.svh
/*
 Constants of the core memory map and special-function register block:
 register addresses, reset values, field positions, memory limits, timings.
 Assumes inclusion by the package and the design modules only.
*/
// Overview of operation
// RULE1 - Program flash serves code addresses 0000h-3FFFh
// RULE2 - Erased flash bytes read back FFh
// RULE3 - Byte writes within 30us, erased locations only
// RULE4 - Whole-array erase completes within 200 ms
// RULE5 - Top N 512-byte blocks reserved for service
// RULE6 - N comes from information block configuration
// RULE7 - Protected external mode blocks code table reads
// RULE8 - Protected flash returns nothing to programmer
// RULE9 - Only whole erase clears the protect bit; the code also clears it on reset
// RULE10 - External moves 0000h-02FFh hit expanded RAM
// RULE11 - Moves above 02FFh drive external bus
// RULE12 - Enable bit gates expanded RAM, reset off
// RULE13 - Lower 128 bytes direct and indirect
// RULE14 - Upper 128 indirect only; direct selects registers
// RULE15 - Bank select places working registers
// RULE16 - Parity flag keeps even ones with accumulator
// RULE17 - Stack pointer resets 07h, pre-increments
// RULE18 - Pointers load as word or bytes
// RULE19 - Select bit chooses the active pointer
// RULE20 - Second accumulator serves multiply, divide, scratch
// RULE21 - Control bits enable programming, inhibit latch strobe
// RULE22 - Unimplemented control bits read zero
`ifndef CMSF_CONSTS_SVH
`define CMSF_CONSTS_SVH

`define CMSF_ADDR_SP        8'h81
`define CMSF_ADDR_P0LO      8'h82
`define CMSF_ADDR_P0HI      8'h83
`define CMSF_ADDR_P1LO      8'h84
`define CMSF_ADDR_P1HI      8'h85
`define CMSF_ADDR_PSEL      8'h86
`define CMSF_ADDR_SYSCTL    8'hBF
`define CMSF_ADDR_PSW       8'hD0
`define CMSF_ADDR_ACC       8'hE0
`define CMSF_ADDR_B         8'hF0

`define CMSF_RST_SP         8'h07
`define CMSF_RST_ZERO       8'h00

`define CMSF_BIT_LSTRB_INH  0
`define CMSF_BIT_XRAM_EN    1
`define CMSF_BIT_ISP_EN     2
`define CMSF_BIT_PSEL       0

`define CMSF_FLASH_TOP      16'h3FFF
`define CMSF_FLASH_END      16'h4000
`define CMSF_ERASED         8'hFF
`define CMSF_XRAM_TOP       16'h02FF
`define CMSF_XRAM_BYTES     768
`define CMSF_SVC_MAX        4'h8
`define CMSF_BIT_AREA_LO    8'h20
`define CMSF_BIT_AREA_HI    8'h2F

`define CMSF_CLK_MHZ        125
`define CMSF_WRITE_US       30
`define CMSF_ERASE_MS       200
`define CMSF_WRITE_CYC      (`CMSF_WRITE_US * `CMSF_CLK_MHZ)
`define CMSF_ERASE_CYC      (`CMSF_ERASE_MS * 1000 * `CMSF_CLK_MHZ)

`endif

// file: pkg/cmsf_pkg.sv
/*
 Types shared by the memory map and register block.
 Assumes the constants header is on the include path.
*/
`include "cmsf_consts.svh"
package cmsf_pkg;
	typedef enum logic [2:0] {
		FL_IDLE  = 3'b001,
		FL_WRITE = 3'b010,
		FL_ERASE = 3'b100
	} cmsf_flash_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} cmsf_sfr_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        wide;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} cmsf_xdata_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd_n;
		logic        wr_n;
		logic [7:0]  wdata;
	} cmsf_ext_bus_t;

	typedef struct packed {
		logic       carry_flag;
		logic       half_carry_flag;
		logic       user_flag_zero;
		logic [1:0] bank_select;
		logic       overflow_flag;
		logic       user_flag_one;
		logic       parity;
	} cmsf_psw_t;
endpackage

// file: hdl/cmsf_flash_array.sv
/*
 Program flash array: 16K bytes with byte write and whole-array erase timing.
 Assumes one request at a time; requests while busy are refused.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cmsf_consts.svh"
module cmsf_flash_array
	import cmsf_pkg::*;
#(
	parameter int unsigned ERASE_CYCLES = `CMSF_ERASE_CYC
) (
	input  wire logic       sys_clk,       // System clock
	input  wire logic       reset_n,       // Synchronous reset
	input  wire logic       clk_en,        // Freezes state when low
	input  wire logic       erase_req,     // Whole-array erase
	input  wire logic       write_req,     // Byte write
	input  wire logic [13:0] wr_addr,      // Write address
	input  wire logic [7:0] wr_data,       // Write data
	input  wire logic [13:0] rd_addr_a,    // Core read address
	input  wire logic [13:0] rd_addr_b,    // Programmer read address
	output logic      [7:0] rd_data_a,     // Core read data
	output logic      [7:0] rd_data_b,     // Programmer read data
	output logic            busy,          // Write or erase running
	output logic            write_refused, // Pulse: write not taken
	output logic            erase_done     // Pulse: erase complete
);
	localparam logic [24:0] WRITE_LAST = 25'(`CMSF_WRITE_CYC - 1);
	localparam logic [24:0] ERASE_LAST = 25'(ERASE_CYCLES - 1);

	logic [7:0]        mem [0:16383];
	cmsf_flash_state_t state_reg;
	cmsf_flash_state_t state_next;
	logic [24:0]       timer_reg;
	logic [13:0]       addr_reg;
	logic [7:0]        data_reg;

	wire logic target_blank = (mem[wr_addr] == `CMSF_ERASED);
	wire logic take_write   = write_req && (state_reg == FL_IDLE) && target_blank; // see RULE3
	wire logic take_erase   = erase_req && (state_reg == FL_IDLE);
	wire logic write_end    = (state_reg == FL_WRITE) && (timer_reg == WRITE_LAST); // see RULE3
	wire logic erase_end    = (state_reg == FL_ERASE) && (timer_reg == ERASE_LAST); // see RULE4

	assign busy = (state_reg != FL_IDLE);

	always_comb begin
		case (state_reg)
			FL_IDLE:  state_next = take_erase ? FL_ERASE : (take_write ? FL_WRITE : FL_IDLE);
			FL_WRITE: state_next = write_end ? FL_IDLE : FL_WRITE;
			FL_ERASE: state_next = erase_end ? FL_IDLE : FL_ERASE;
			default:  state_next = FL_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			state_reg     <= FL_IDLE;
			timer_reg     <= '0;
			addr_reg      <= '0;
			data_reg      <= '0;
			write_refused <= 1'b0;
			erase_done    <= 1'b0;
			rd_data_a     <= '0;
			rd_data_b     <= '0;
		end else if (clk_en) begin
			state_reg     <= state_next;
			timer_reg     <= (state_next == state_reg && busy) ? timer_reg + 25'd1 : '0;
			write_refused <= write_req && !take_write && !take_erase;
			erase_done    <= erase_end;
			rd_data_a     <= mem[rd_addr_a];
			rd_data_b     <= mem[rd_addr_b];
			if (take_write) begin
				addr_reg <= wr_addr;
				data_reg <= wr_data;
			end
		end
	end

	// Array contents are not reset: they survive a reset like real flash
	always_ff @(posedge sys_clk) begin
		if (clk_en && write_end)
			mem[addr_reg] <= data_reg;
		if (clk_en && erase_end) begin
			for (int i = 0; i < 16384; i++)
				mem[i] <= `CMSF_ERASED; // see RULE2
		end
	end
endmodule
`default_nettype wire

// file: test/cmsf_checker.sv
/* Port assertions for the register block.
   Assumes binding into every instance of the top module. */
`timescale 1ns/1ps
`default_nettype none
module cmsf_checker
	import cmsf_pkg::*;
(
	input wire logic            sys_clk,                 // Clock
	input wire logic            reset_n,                 // Reset
	input wire logic            clk_en,                  // Enable
	input wire logic            push_req,                // Push
	input wire logic            pop_req,                 // Pop
	input wire logic [7:0]      accumulator,             // Acc
	input wire logic [7:0]      program_status,          // Status
	input wire logic [7:0]      stack_pointer,           // Stack
	input wire logic [7:0]      bank_base,               // Bank
	input wire logic [15:0]     fetch_addr,              // Code addr
	input wire logic            fetch_external,          // Beyond flash
	input wire logic            table_rd,                // Table read
	input wire logic            external_program_select, // Pin
	input wire logic            table_read_blocked,      // Blocked
	input wire logic            code_protected,          // Protect
	input wire logic            flash_busy,              // Busy
	input wire logic [7:0]      prog_rdata,              // Prog data
	input wire cmsf_xdata_req_t xd_req,                  // Move
	input wire cmsf_ext_bus_t   ext_bus,                 // Ext bus
	input wire logic            xd_valid                 // Move valid
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_ext_rd;
		!ext_bus.rd_n ##1 (ext_bus.rd_n && xd_valid);
	endsequence
	a_parity_even: assert property (program_status[0] == ^accumulator)
		else $error("parity flag wrong");
	a_bank_base_map: assert property (bank_base == {3'b000, program_status[4:3], 3'b000})
		else $error("bank base wrong");
	a_stack_pre_inc: assert property (push_req && !pop_req && clk_en |=> stack_pointer == $past(stack_pointer) + 8'h01)
		else $error("push did not pre-increment");
	a_stack_reset_val: assert property ($rose(reset_n) |-> stack_pointer == 8'h07)
		else $error("stack reset value wrong");
	a_fetch_range: assert property (fetch_external == (fetch_addr > 16'h3FFF))
		else $error("flash range decode wrong");
	a_table_block: assert property (table_read_blocked == (table_rd && code_protected && !external_program_select))
		else $error("table read block wrong");
	a_prog_hidden: assert property ($past(code_protected) && code_protected |-> prog_rdata == 8'h00)
		else $error("protected flash leaked");
	a_protect_hold: assert property (code_protected && !$past(flash_busy) |=> code_protected)
		else $error("protection cleared without erase");
	a_ext_read_seq: assert property (xd_req.rd && xd_req.wide && xd_req.addr > 16'h02FF && clk_en |=> s_ext_rd)
		else $error("external read strobe wrong");
endmodule
bind cmsf_core_regs cmsf_checker i_chk (.*);
`default_nettype wire

// file: test/cmsf_ext_mem.sv
/* External data memory on the far side of the move bus.
   Assumes one strobe at a time; aliases on the low address byte. */
`timescale 1ns/1ps
`default_nettype none
module cmsf_ext_mem
	import cmsf_pkg::*;
(
	input  wire logic          sys_clk,   // Clock
	input  wire cmsf_ext_bus_t ext_bus,   // Bus from block
	output logic         [7:0] ext_rdata  // Read data
);
	logic [7:0] mem [0:255];
	logic [7:0] last_reg = 8'h00;
	// Released bus shows the inverse of the last byte, never a held value
	assign ext_rdata = ext_bus.rd_n ? ~last_reg : mem[ext_bus.addr[7:0]];
	always @(posedge sys_clk) begin
		if (!ext_bus.wr_n) mem[ext_bus.addr[7:0]] <= ext_bus.wdata;
		if (!ext_bus.rd_n) last_reg <= ext_rdata;
	end
endmodule
`default_nettype wire

// file: test/cmsf_core_regs_tb.sv
/* Self-checking bench for the register block.
   Assumes the checker and external memory model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_total++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module cmsf_core_regs_tb
	import cmsf_pkg::*;
;
	logic sys_clk = 0, reset_n = 0, clk_en = 1, iram_indirect = 0, iram_rn_sel = 0, iram_wr = 0, push_req = 0;
	logic pop_req = 0, acc_load = 0, b_load = 0, flags_load = 0, data_pointer0_load16 = 0, table_rd = 0, latch_tick = 0;
	logic external_program_select = 1, iap_write = 0, prog_erase = 0, prog_write = 0, prog_protect_set = 0;
	logic [7:0] iram_addr = 0, iram_wdata = 0, push_data = 0, acc_in = 0, b_in = 0, prog_wdata = 0, ext_rdata;
	logic [2:0] iram_rn_idx = 0, flags_in = 0;
	logic [3:0] info_service_blocks = 4'h2;
	logic [13:0] prog_addr = 0;
	logic [15:0] data_pointer0_in = 0, fetch_addr = 0, active_pointer;
	cmsf_sfr_req_t sfr_req = '0;
	cmsf_xdata_req_t xd_req = '0;
	cmsf_ext_bus_t ext_bus;
	logic [7:0] sfr_rdata, iram_rdata, pop_data, accumulator, second_accumulator, program_status, stack_pointer;
	logic [7:0] bank_base, code_rdata, xd_rdata, prog_rdata;
	logic direct_is_sfr, in_bit_area, fetch_external, table_read_blocked, fetch_in_service, xd_valid, latch_strobe;
	logic insys_prog_enable, code_protected, flash_busy, flash_refused;
	logic [14:0] service_base;
	int err_total = 0, checks_done = 0;
	always #4 sys_clk = ~sys_clk;
	cmsf_core_regs #(.ERASE_CYCLES(50)) i_dut (.*);
	cmsf_ext_mem i_mem (.sys_clk(sys_clk), .ext_bus(ext_bus), .ext_rdata(ext_rdata));
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic sfr_wr(input logic [7:0] a, d);
		sfr_req = '{a, 1'b1, d};
		cyc(1);
	endtask
	task automatic sfr_chk(input logic [7:0] a, e);
		sfr_req = '{a, 1'b0, 8'h00};
		cyc(1);
		`CHK(sfr_rdata, e)
	endtask
	task automatic xd(input logic [15:0] a, input logic r, input logic [7:0] d);
		xd_req = '{a, 1'b1, r, !r, d};
		cyc(1);
	endtask
	task automatic wait_idle(input int lim);
		int n = 0;
		while (flash_busy !== 1'b0 && n < lim) begin
			cyc(1);
			n++;
		end
		`CHK(n < lim, 1'b1)
	endtask
	task automatic t_reset();
		logic [7:0] tbl [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'hBF, 8'hD0, 8'hE0, 8'hF0};
		foreach (tbl[i]) sfr_chk(tbl[i], (i == 0) ? 8'h07 : 8'h00);
		`CHK({fetch_in_service, service_base}, 16'h3C00)
	endtask
	task automatic t_regs();
		sfr_wr(8'h86, 8'hFF);
		sfr_chk(8'h86, 8'h01);
		sfr_wr(8'h84, 8'h34);
		sfr_wr(8'h85, 8'h12);
		`CHK(active_pointer, 16'h1234)
		sfr_wr(8'h86, 8'h00);
		data_pointer0_in = 16'hABCD;
		pulse(data_pointer0_load16);
		sfr_chk(8'h82, 8'hCD);
		sfr_wr(8'hF0, 8'h5A);
		`CHK(second_accumulator, 8'h5A)
		latch_tick = 1'b1;
		sfr_wr(8'hBF, 8'hFF);
		sfr_chk(8'hBF, 8'h07);
		`CHK({insys_prog_enable, latch_strobe}, 2'b10)
		sfr_wr(8'hBF, 8'h02);
		`CHK({insys_prog_enable, latch_strobe}, 2'b01)
		latch_tick = 1'b0;
	endtask
	task automatic t_status();
		for (int i = 0; i < 4; i++) begin
			sfr_wr(8'hD0, 8'(i << 3));
			`CHK(bank_base, 8'(i * 8))
			acc_in = 8'((1 << i) - 1);
			pulse(acc_load);
			`CHK(program_status[0], 1'(i & 1))
		end
	endtask
	task automatic t_ram();
		push_data = 8'h55;
		pulse(push_req);
		`CHK(stack_pointer, 8'h08)
		pulse(pop_req);
		`CHK({pop_data, stack_pointer}, 16'h5507)
		{iram_addr, iram_wdata, iram_indirect} = {8'hC0, 8'hA5, 1'b1};
		pulse(iram_wr);
		cyc(1);
		`CHK(iram_rdata, 8'hA5)
		{iram_addr, iram_indirect} = {8'h2F, 1'b0};
		cyc(1);
		`CHK({in_bit_area, direct_is_sfr}, 2'b10)
		iram_addr = 8'hC0;
		cyc(1);
		`CHK(direct_is_sfr, 1'b1)
	endtask
	task automatic t_xdata();
		xd(16'h02FF, 1'b0, 8'hC3);
		`CHK(ext_bus.wr_n, 1'b1)
		xd(16'h02FF, 1'b1, 8'h00);
		`CHK({xd_valid, xd_rdata}, 9'h1C3)
		xd(16'h0300, 1'b0, 8'h3C);
		`CHK({ext_bus.wr_n, ext_bus.addr}, 17'h0_0300)
		xd(16'h0300, 1'b1, 8'h00);
		xd_req = '0;
		cyc(1);
		`CHK({xd_valid, xd_rdata}, 9'h13C)
		sfr_wr(8'hBF, 8'h00);
		xd(16'h0010, 1'b1, 8'h00);
		`CHK(ext_bus.rd_n, 1'b0)
		xd_req = '0;
	endtask
	task automatic t_flash();
		pulse(prog_erase);
		wait_idle(52);
		{prog_addr, prog_wdata, fetch_addr} = {14'h0100, 8'h5A, 16'h0100};
		cyc(1);
		`CHK(prog_rdata, 8'hFF)
		pulse(prog_write);
		wait_idle(3752);
		cyc(1);
		`CHK(code_rdata, 8'h5A)
		pulse(prog_write);
		`CHK(flash_refused, 1'b1)
		pulse(prog_protect_set);
		cyc(1);
		`CHK(prog_rdata, 8'h00)
		{table_rd, external_program_select} = 2'b10;
		cyc(1);
		`CHK(table_read_blocked, 1'b1)
		{table_rd, external_program_select} = 2'b01;
		pulse(prog_erase);
		wait_idle(52);
		cyc(1);
		`CHK(code_protected, 1'b0)
	endtask
	task automatic end_sim();
		if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		cyc(20000);
		err_total++;
		end_sim();
	end
	initial begin
		cyc(10);
		reset_n = 1'b1;
		cyc(1);
		t_reset();
		t_regs();
		t_status();
		t_ram();
		t_xdata();
		t_flash();
		end_sim();
	end
endmodule
`default_nettype wire
